// [src/pm_pkg.sv]
/*
 * Shared constants and types of the power monitor serial slave: register pointers,
 * reset values, field positions, arithmetic divisors, timing counts and state types.
 * Assumes a 25 MHz system clock; all cycle counts are derived from it here.
 */
package pm_pkg;

    // System clock rate.
    localparam int CLK_KHZ = 25000;
    localparam int CLK_PERIOD_NS = 40;

    // Register pointer values.
    localparam logic [7:0] PTR_CONFIG = 8'h00;
    localparam logic [7:0] PTR_SHUNT = 8'h01;
    localparam logic [7:0] PTR_BUS = 8'h02;
    localparam logic [7:0] PTR_POWER = 8'h03;
    localparam logic [7:0] PTR_CURRENT = 8'h04;
    localparam logic [7:0] PTR_CALIB = 8'h05;

    // Reset values: 12-bit, gain /8, 32 V range, continuous shunt and bus conversion.
    localparam logic [15:0] CFG_RESET = 16'h399f;
    localparam logic [15:0] CAL_RESET = 16'h0000;

    // Configuration fields.
    localparam int CFG_SOFT_RST_BIT = 15;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MODE_W = 3;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
    localparam logic [2:0] MODE_ADC_OFF = 3'h4;

    // Result scaling.
    localparam int SHUNT_LSB_UV = 10;
    localparam int BUS_LSB_MV = 4;
    localparam int BUS_SHIFT = 3;
    localparam int BUS_RESULT_W = 13;
    localparam int CONV_FLAG_BIT = 1;
    localparam int CUR_DIVISOR = 4096;
    localparam int PWR_DIVISOR = 5000;

    // Address layout and special codes.
    localparam logic [2:0] ADDR_BASE = 3'h4;
    localparam logic [4:0] HS_MASTER_CODE = 5'h01;

    // Interface timeout.
    localparam int TMO_MS = 28;
    localparam int TMO_CYCLES = TMO_MS * CLK_KHZ;
    localparam int TMO_W = 20;

    // Write apply latency bound; writes land as the eighth data bit is taken in, well inside it.
    localparam int APPLY_MAX_US = 4;
    localparam int APPLY_MAX_CYCLES = APPLY_MAX_US * CLK_KHZ / 1000;

    // Spike filter lengths in ns and cycles (rounded down, at least one cycle).
    localparam int FS_FILT_NS = 80;
    localparam int HS_FILT_NS = 40;
    localparam logic [1:0] FS_FILT_CYC = 2'((FS_FILT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (FS_FILT_NS / CLK_PERIOD_NS));
    localparam logic [1:0] HS_FILT_CYC = 2'((HS_FILT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (HS_FILT_NS / CLK_PERIOD_NS));

    // Transaction states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_RX       = 6'b000010,
        ST_ACK_WAIT = 6'b000100,
        ST_ACK_DRV  = 6'b001000,
        ST_TX       = 6'b010000,
        ST_ACK_RX   = 6'b100000
    } state_t;

    // One spike-filtered line.
    typedef struct packed {
        logic val;
        logic [1:0] cnt;
    } filt_t;

    // State of the link-clock side.
    typedef struct packed {
        logic bit_val;
        logic tog;
    } link_state_t;

    // State of the system-clock side.
    typedef struct packed {
        state_t st;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [2:0] tog_s;
        logic [3:0] pin_lo_s;
        logic [3:0] pin_hi_s;
        filt_t scl_f;
        filt_t sda_f;
        logic [6:0] own_addr;
        logic [3:0] cnt;
        logic [1:0] byte_idx;
        logic rw;
        logic fresh;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [7:0] wr_hi;
        logic [15:0] rd_word;
        logic [7:0] tx;
        logic oe;
        logic sda_o;
        logic hs;
        logic conversion_complete_flag;
        logic [15:0] cfg;
        logic [15:0] cal;
        logic [15:0] current;
        logic [15:0] power;
        logic [TMO_W-1:0] tmo;
    } sys_state_t;

endpackage

// [src/power_monitor_i2c_slave.sv]
/*
 * Two-wire serial slave and result arithmetic of a current, voltage and power monitor.
 * Bits are captured on the serial clock's own rising edge; framing, pointer, registers
 * and the data line driver run on the system clock. The front end supplies shunt and bus
 * results and a conversion-done pulse on the system clock. The serial clock pin feeds
 * i_scl_clk, which also stands still between frames.
 */
// Overview of operation
// - Shunt register holds the shunt result with a 10 microvolt step.
// - Bus register carries the bus result shifted left by three, 4 mV step.
// - Current equals shunt times calibration divided by 4096.
// - Power equals current times bus result divided by 5000.
// - Configuration resets to 12-bit, gain /8, 32 V, continuous both.
// - With calibration zero, current and power stay zero.
// - First byte is seven address bits plus direction; address compared.
// - Own address is 100 then high pin code then low pin code.
// - Address pins are sampled at the start of every transaction.
// - START is data falling with clock high; bits shift in on clock rise.
// - An addressed device pulls data low in the ninth clock of each byte it receives.
// - Data edges while clock is high are START or STOP.
// - A transaction stalled for 28 ms is abandoned and the bus released.
// - Slave only; fast and high-speed clock rates supported.
// - Register words go most significant byte first both ways.
// - First byte after a write address loads the register pointer.
// - Two data bytes after the pointer are stored, each acknowledged.
// - Pointer-only write then repeated START with read address selects reads.
// - Read sends high byte, waits master acknowledge, then low byte.
// - Master not-acknowledge, START or STOP ends a read; data released.
// - Pointer survives reads; only a new write pointer changes it.
// - High-speed master code is not acknowledged, selects short filtering until STOP.
// - Written data lands within 4 microseconds of the write.
// - Reading the bus register clears the conversion-complete flag.
`timescale 1ns/100ps
module power_monitor_i2c_slave
    import pm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TMO_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl_clk,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic [1:0] i_addr_select_low_pin,
    input wire logic [1:0] i_addr_select_high_pin,
    input wire logic signed [15:0] i_shunt_value,
    input wire logic [BUS_RESULT_W-1:0] i_bus_result,
    input wire logic i_conversion_done,
    output logic [15:0] o_config_q,
    output logic o_hs_mode_q
);

    link_state_t link_q;
    link_state_t link_d;
    sys_state_t q;
    sys_state_t d;

    // Spike filter step: the output follows the input only after it differs long enough.
    function automatic filt_t filt_step(input filt_t f, input logic raw,
                                        input logic [1:0] len);
        filt_t r;
        r = f;
        if (raw == f.val) begin
            r.cnt = 2'h0;
        end else if (f.cnt + 2'h1 >= len) begin
            r.val = raw;
            r.cnt = 2'h0;
        end else begin
            r.cnt = f.cnt + 2'h1;
        end
        return r;
    endfunction

    // Register read decode; unimplemented pointers read as zero.
    function automatic logic [15:0] rd_reg(input sys_state_t s, input logic [7:0] p,
                                           input logic signed [15:0] shunt,
                                           input logic [BUS_RESULT_W-1:0] bus);
        logic [15:0] v;
        v = 16'h0000;
        case (p)
            PTR_CONFIG: v = s.cfg;
            PTR_SHUNT: v = shunt;
            PTR_BUS: begin
                v = 16'({bus, {BUS_SHIFT{1'b0}}});
                v[CONV_FLAG_BIT] = s.conversion_complete_flag;
            end
            PTR_POWER: v = s.power;
            PTR_CURRENT: v = s.current;
            PTR_CALIB: v = s.cal;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Link side: sample data on each serial clock rise and flag it with a toggle.
    always_comb begin
        link_d = link_q;
        link_d.bit_val = i_sda_i;
        link_d.tog = ~link_q.tog;
    end

    // Link side register.
    always_ff @(posedge i_scl_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // System side next state: framing, byte handling, registers and arithmetic.
    always_comb begin
        logic [1:0] flen;
        filt_t nscl;
        filt_t nsda;
        logic ev_start;
        logic ev_stop;
        logic ev_fall;
        logic ev_bit;
        logic [7:0] byte_in;
        logic [15:0] wword;
        logic signed [32:0] cur_prod;
        logic signed [32:0] cur_quot;
        logic signed [29:0] pwr_prod;
        logic signed [29:0] pwr_quot;
        d = q;
        flen = q.hs ? HS_FILT_CYC : FS_FILT_CYC;
        nscl = filt_step(q.scl_f, q.scl_s[1], flen);
        nsda = filt_step(q.sda_f, q.sda_s[1], flen);
        byte_in = {q.sh[6:0], link_q.bit_val};
        wword = {q.wr_hi, byte_in};
        cur_prod = 33'sd0;
        cur_quot = 33'sd0;
        pwr_prod = 30'sd0;
        pwr_quot = 30'sd0;

        // Two-stage synchronisers, three stages for the toggle; only the later stages are read further on.
        d.scl_s = {q.scl_s[0], i_scl_clk};
        d.sda_s = {q.sda_s[0], i_sda_i};
        d.tog_s = {q.tog_s[1:0], link_q.tog};
        d.pin_lo_s = {q.pin_lo_s[1:0], i_addr_select_low_pin};
        d.pin_hi_s = {q.pin_hi_s[1:0], i_addr_select_high_pin};
        d.scl_f = nscl;
        d.sda_f = nsda;

        // Line events from the filtered levels; bit events from the synchronised toggle.
        ev_start = q.scl_f.val & nscl.val & q.sda_f.val & ~nsda.val;
        ev_stop = q.scl_f.val & nscl.val & ~q.sda_f.val & nsda.val;
        ev_fall = q.scl_f.val & ~nscl.val;
        ev_bit = q.tog_s[2] ^ q.tog_s[1];
        d.sda_o = 1'b0;

        // Stall watchdog runs only inside a transaction.
        if (q.st == ST_IDLE || ev_fall || ev_bit) begin
            d.tmo = '0;
        end else begin
            d.tmo = q.tmo + TMO_W'(1);
        end

        case (q.st)
            ST_IDLE: begin
                d.oe = 1'b0;
            end
            ST_RX: begin
                // Shift a byte in and decide on it after the eighth bit.
                if (ev_bit) begin
                    d.sh = byte_in;
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        d.st = ST_ACK_WAIT;
                        case (q.byte_idx)
                            2'h0: begin
                                if (byte_in[7:3] == HS_MASTER_CODE) begin
                                    d.hs = 1'b1;
                                    d.st = ST_IDLE;
                                end else if (byte_in[7:1] == q.own_addr) begin
                                    d.rw = byte_in[0];
                                    d.byte_idx = byte_in[0] ? 2'h2 : 2'h1;
                                    if (byte_in[0]) begin
                                        // Snapshot the whole word so both bytes match.
                                        d.rd_word = rd_reg(q, q.ptr, i_shunt_value,
                                                           i_bus_result);
                                        if (q.ptr == PTR_BUS) begin
                                            d.conversion_complete_flag = 1'b0;
                                        end
                                    end
                                end else begin
                                    d.st = ST_IDLE;
                                end
                            end
                            2'h1: begin
                                d.ptr = byte_in;
                                d.byte_idx = 2'h2;
                            end
                            2'h2: begin
                                d.wr_hi = byte_in;
                                d.byte_idx = 2'h3;
                            end
                            default: begin
                                // Low byte completes the word; apply it at once.
                                d.byte_idx = 2'h2;
                                case (q.ptr)
                                    PTR_CONFIG: begin
                                        if (wword[CFG_SOFT_RST_BIT]) begin
                                            d.cfg = CFG_RESET;
                                            d.cal = CAL_RESET;
                                            d.conversion_complete_flag = 1'b0;
                                        end else begin
                                            d.cfg = wword;
                                            if (wword[CFG_MODE_LSB +: CFG_MODE_W] !=
                                                    MODE_POWER_DOWN &&
                                                    wword[CFG_MODE_LSB +: CFG_MODE_W] !=
                                                    MODE_ADC_OFF) begin
                                                d.conversion_complete_flag = 1'b0;
                                            end
                                        end
                                    end
                                    PTR_CALIB: d.cal = wword;
                                    default: d.cal = q.cal;
                                endcase
                            end
                        endcase
                    end
                end
            end
            ST_ACK_WAIT: begin
                // Pull data low once the eighth clock has fallen.
                if (ev_fall) begin
                    d.oe = 1'b1;
                    d.st = ST_ACK_DRV;
                end
            end
            ST_ACK_DRV: begin
                // Release after the ninth clock, or present the first read bit.
                if (ev_fall) begin
                    d.cnt = 4'h0;
                    if (q.rw) begin
                        d.tx = q.rd_word[15:8];
                        d.oe = ~q.rd_word[15];
                        d.fresh = 1'b0;
                        d.st = ST_TX;
                    end else begin
                        d.oe = 1'b0;
                        d.st = ST_RX;
                    end
                end
            end
            ST_TX: begin
                // Count clock rises; move the next bit out on each fall.
                if (ev_bit) begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (ev_fall) begin
                    if (q.fresh) begin
                        d.oe = ~q.tx[7];
                        d.fresh = 1'b0;
                    end else if (q.cnt == 4'h8) begin
                        d.oe = 1'b0;
                        d.st = ST_ACK_RX;
                    end else begin
                        d.tx = {q.tx[6:0], 1'b0};
                        d.oe = ~q.tx[6];
                    end
                end
            end
            ST_ACK_RX: begin
                // Master acknowledge continues the read; not-acknowledge ends it.
                if (ev_bit) begin
                    d.cnt = 4'h0;
                    d.fresh = 1'b1;
                    if (link_q.bit_val) begin
                        d.st = ST_IDLE;
                    end else if (q.byte_idx == 2'h2) begin
                        d.tx = q.rd_word[7:0];
                        d.byte_idx = 2'h3;
                        d.st = ST_TX;
                    end else begin
                        d.rd_word = rd_reg(q, q.ptr, i_shunt_value, i_bus_result);
                        d.tx = d.rd_word[15:8];
                        d.byte_idx = 2'h2;
                        if (q.ptr == PTR_BUS) begin
                            d.conversion_complete_flag = 1'b0;
                        end
                        d.st = ST_TX;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
                d.oe = 1'b0;
            end
        endcase

        // Abandon a stalled transaction.
        if (q.st != ST_IDLE && q.tmo >= TMO_W'(TIMEOUT_CYCLES - 1)) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
        end

        // START and STOP override everything; pins are sampled on every START.
        if (ev_start) begin
            d.st = ST_RX;
            d.cnt = 4'h0;
            d.byte_idx = 2'h0;
            d.oe = 1'b0;
            d.tmo = '0;
            d.own_addr = {ADDR_BASE, q.pin_hi_s[3:2], q.pin_lo_s[3:2]};
        end else if (ev_stop) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
            d.hs = 1'b0;
        end

        // Conversion done sets the flag and wins over any clear in the same cycle.
        if (i_conversion_done) begin
            d.conversion_complete_flag = 1'b1;
        end

        // Current and power results; a zero calibration yields zero.
        cur_prod = $signed(i_shunt_value) * $signed({1'b0, q.cal});
        cur_quot = cur_prod / $signed(33'(CUR_DIVISOR));
        d.current = cur_quot[15:0];
        pwr_prod = $signed(q.current) * $signed({1'b0, i_bus_result});
        pwr_quot = pwr_prod / $signed(30'(PWR_DIVISOR));
        d.power = pwr_quot[15:0];
    end

    // System side register; lines idle high, configuration at its documented default.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.scl_s <= 2'h3;
            q.sda_s <= 2'h3;
            q.scl_f <= '{val: 1'b1, cnt: 2'h0};
            q.sda_f <= '{val: 1'b1, cnt: 2'h0};
            q.cfg <= CFG_RESET;
            q.cal <= CAL_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state flops; the device only ever pulls data low.
    assign o_sda_o = q.sda_o;
    assign o_sda_oe = q.oe;
    assign o_config_q = q.cfg;
    assign o_hs_mode_q = q.hs;

endmodule

// [verification/bus_mst.sv]
/* Serial bus master model: drives the clock and pulls data low.
   Assumes the bench resolves the pulled-up data wire. */
`timescale 1ns/100ps
module bus_mst (
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    // Quarter bit time, slower than the link rate so the slave filters can follow.
    localparam int Q = 151;
    // Bus idles released with the clock high.
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        o_sda_low = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_low = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    // Stop: data rises while the clock is high, then the clock stands still.
    task automatic stop();
        o_sda_low = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_low = 1'b0;
        #Q;
    endtask
    // One bit: data changes only while the clock is low.
    task automatic clk_bit(input logic b, output logic s);
        o_sda_low = !b;
        #Q o_scl = 1'b1;
        #Q s = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    // Sends a byte first bit most significant and returns the acknowledge bit.
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, ack);
    endtask
    // Receives a byte, then acknowledges it or not.
    task automatic get_byte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(!mack, s);
    endtask
endmodule

// [verification/pm_slave_assertions.sv]
/* Port checks for the serial slave.
   Bound to every power_monitor_i2c_slave instance. */
`timescale 1ns/100ps
module pm_slave_checker
    import pm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TMO_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl_clk,
    input wire logic i_sda_i,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic [15:0] o_config_q,
    input wire logic o_hs_mode_q
);
    logic [20:0] stall_q;
    logic [20:0] stall_d;
    logic scl_q;
    // Counts cycles the data line is held while the serial clock stands still.
    always_comb begin
        stall_d = (o_sda_oe && i_scl_clk == scl_q) ? stall_q + 21'h1 : 21'h0;
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stall_q <= 21'h0;
            scl_q <= 1'b1;
        end else begin
            stall_q <= stall_d;
            scl_q <= i_scl_clk;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_drive_low: assert property (o_sda_oe |-> !o_sda_o)
        else $error("data driven high");
    chk_reset_cfg: assert property ($fell(i_sys_rst) |-> o_config_q == 16'h399f)
        else $error("config not at default after reset");
    chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl_clk)
        else $error("data drive changed with clock high");
    chk_stop_hs_clr: assert property ((i_scl_clk && $rose(i_sda_i)) |-> ##[1:8] !o_hs_mode_q)
        else $error("high speed mode kept after stop");
    chk_stop_release: assert property ((i_scl_clk && $rose(i_sda_i)) |-> !o_sda_oe [*6])
        else $error("data driven after stop");
    chk_cfg_write: assert property ($changed(o_config_q) |-> !o_sda_oe)
        else $error("config changed outside a received byte");
    chk_stall_bound: assert property (stall_q <= 21'(TIMEOUT_CYCLES + 16))
        else $error("stalled transfer not released");
    chk_hs_no_ack: assert property ($rose(o_hs_mode_q) |-> !o_sda_oe [*8])
        else $error("high speed code acknowledged");
endmodule

bind power_monitor_i2c_slave pm_slave_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl_clk(i_scl_clk), .i_sda_i(i_sda_i),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_config_q(o_config_q),
    .o_hs_mode_q(o_hs_mode_q));

// [verification/testbench.sv]
/* Self-checking bench for the power monitor serial slave.
   Uses the bus_mst model as the far side and a short timeout count. */
`timescale 1ns/100ps
module testbench
    import pm_pkg::*;
;
    localparam int TMO = 2000;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b0;
    logic [1:0] pin_lo = 2'h0;
    logic [1:0] pin_hi = 2'h0;
    logic signed [15:0] shunt = 16'sh0;
    logic [12:0] bus = 13'h0;
    logic done = 1'b0;
    logic scl, m_low, oe, sda_o, hs;
    logic [15:0] cfg;
    wire sda = !(m_low || (oe && !sda_o));
    wire [6:0] adr = {3'h4, pin_hi, pin_lo};
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    power_monitor_i2c_slave #(.TIMEOUT_CYCLES(TMO)) power_monitor_i2c_slave_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl_clk(scl), .i_sda_i(sda),
        .o_sda_o(sda_o), .o_sda_oe(oe), .i_addr_select_low_pin(pin_lo),
        .i_addr_select_high_pin(pin_hi), .i_shunt_value(shunt), .i_bus_result(bus),
        .i_conversion_done(done), .o_config_q(cfg), .o_hs_mode_q(hs));
    bus_mst bus_mst_inst (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
    // System clock and watchdog.
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 95000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] exp_cur(input logic [15:0] s, input logic [15:0] c);
        return 16'(({16'h0, s} * {16'h0, c}) / 32'd4096);
    endfunction
    function automatic logic [15:0] exp_pwr(input logic [15:0] c, input logic [12:0] b);
        return 16'(({16'h0, c} * {19'h0, b}) / 32'd5000);
    endfunction
    // New pins and results, then two clocks and a step off the clock edge.
    task automatic drive(input logic [3:0] pins);
        @(posedge i_clk);
        {pin_hi, pin_lo} <= pins;
        shunt <= 16'($urandom_range(16'h7fff));
        bus <= 13'($urandom);
        repeat (2) @(posedge i_clk);
        #7;
    endtask
    // Sends one byte that must be acknowledged.
    task automatic pb(input logic [7:0] b);
        logic a;
        bus_mst_inst.put_byte(b, a);
        check({15'h0, a}, 16'h0);
    endtask
    // m[0] pointer, m[1] word write, m[2] word read after a (repeated) start.
    task automatic xfer(input logic [2:0] m, input logic [7:0] p, input logic [15:0] w,
                        output logic [15:0] r);
        if (m[0]) begin
            bus_mst_inst.start();
            pb({adr, 1'b0});
            pb(p);
        end
        if (m[1]) begin
            pb(w[15:8]);
            pb(w[7:0]);
        end
        if (m[2]) begin
            bus_mst_inst.start();
            pb({adr, 1'b1});
            bus_mst_inst.get_byte(1'b1, r[15:8]);
            bus_mst_inst.get_byte(1'b0, r[7:0]);
        end
        bus_mst_inst.stop();
    endtask
    // Main sequence.
    initial begin
        logic [15:0] r, c, w;
        logic [7:0] nb [2];
        logic a;
        // A real reset edge also clears the link side, which only the serial clock advances.
        i_sys_rst <= 1'b1;
        void'($urandom(32'h80e4));
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        drive(4'h5);
        check(cfg, 16'h399f);
        xfer(3'b101, PTR_CURRENT, 16'h0, r);
        check(r, 16'h0);
        $display("test defaults done");
        for (int i = 0; i < 16; i++) begin
            drive(4'(i));
            c = (i == 0) ? 16'h1000 : 16'($urandom_range(4096, 1));
            xfer(3'b011, PTR_CALIB, c, r);
            xfer(3'b101, PTR_CURRENT, 16'h0, r);
            check(r, exp_cur(shunt, c));
            xfer(3'b101, PTR_POWER, 16'h0, r);
            check(r, exp_pwr(exp_cur(shunt, c), bus));
            xfer(3'b101, PTR_SHUNT + 8'(i % 2), 16'h0, r);
            check(r, (i % 2) ? {bus, 3'h0} : shunt);
        end
        $display("test arithmetic done");
        xfer(3'b001, PTR_SHUNT, 16'h0, r);
        repeat (2) begin
            xfer(3'b100, 8'h0, 16'h0, r);
            check(r, shunt);
        end
        xfer(3'b111, 8'h07, 16'(~shunt), r);
        check(r, 16'h0);
        check(cfg, 16'h399f);
        $display("test pointer done");
        @(posedge i_clk) done <= 1'b1;
        @(posedge i_clk) done <= 1'b0;
        repeat (2) @(posedge i_clk);
        #7;
        xfer(3'b101, PTR_BUS, 16'h0, r);
        check({15'h0, r[1]}, 16'h1);
        xfer(3'b100, 8'h0, 16'h0, r);
        check({15'h0, r[1]}, 16'h0);
        $display("test flag done");
        nb[0] = 8'h0b;
        nb[1] = {adr ^ 7'h01, 1'b0};
        for (int k = 0; k < 2; k++) begin
            bus_mst_inst.start();
            bus_mst_inst.put_byte(nb[k], a);
            check({15'h0, a}, 16'h1);
            check({15'h0, hs}, 16'(k == 0));
            bus_mst_inst.stop();
            repeat (10) @(posedge i_clk);
            check({15'h0, hs}, 16'h0);
        end
        $display("test refusals done");
        w = 16'($urandom) & 16'h7fff;
        xfer(3'b111, PTR_CONFIG, w, r);
        check(r, w);
        check(cfg, w);
        // The reset bit restores configuration and calibration defaults.
        xfer(3'b011, PTR_CONFIG, 16'h8000 | w, r);
        check(cfg, 16'h399f);
        xfer(3'b101, PTR_CALIB, 16'h0, r);
        check(r, 16'h0);
        $display("test config done");
        bus_mst_inst.start();
        pb({adr, 1'b1});
        repeat (10) @(posedge i_clk);
        check({15'h0, oe}, 16'h1);
        repeat (TMO + 50) @(posedge i_clk);
        check({15'h0, oe}, 16'h0);
        bus_mst_inst.stop();
        $display("test timeout done");
        tally_and_finish();
    end
endmodule
